// *** verilog/sdc_pkg.sv ***
`default_nettype none
package sdc_pkg;
  localparam int M_W      = 9;
  localparam int N_W      = 2;
  localparam int T_W      = 3;
  localparam int SR_W     = T_W + N_W + M_W;
  localparam int REF_PRE  = 16;
  localparam int M_MIN    = 200;
  localparam int M_MAX    = 400;

  localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
  localparam logic [31:0] REG_PAR    = 32'h0000_0004;
  localparam logic [31:0] REG_SHIFT  = 32'h0000_0008;
  localparam logic [31:0] REG_CFG    = 32'h0000_000c;
  localparam logic [31:0] REG_STAT   = 32'h0000_0010;

  localparam logic [M_W-1:0] M_RST = 9'h100;
  localparam logic [N_W-1:0] N_RST = 2'h0;
  localparam logic [T_W-1:0] T_RST = 3'h0;

  localparam logic [T_W-1:0] T_SHIFT  = 3'h0;
  localparam logic [T_W-1:0] T_HIGH   = 3'h1;
  localparam logic [T_W-1:0] T_REF    = 3'h2;
  localparam logic [T_W-1:0] T_MHALF  = 3'h3;
  localparam logic [T_W-1:0] T_SYNTH  = 3'h4;
  localparam logic [T_W-1:0] T_LOW    = 3'h5;
  localparam logic [T_W-1:0] T_BYPASS = 3'h6;
  localparam logic [T_W-1:0] T_QUART  = 3'h7;

  localparam int SYNC_N = 3;
endpackage
`default_nettype wire

// *** verilog/sdc_divider.sv ***
`default_nettype none
// Modulo-count divider; emits a one-cycle enable every ratio input enables.
module sdc_divider #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Control
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio,
  // Result
  output logic              tick_out,
  output logic              half_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         half;
  } sdc_div_st_t;
  sdc_div_st_t st_reg;
  sdc_div_st_t st_next;
  logic        wrap;

  // A ratio of zero or one passes every enable through
  assign wrap     = tick_in && ((ratio <= W'(1)) || (st_reg.cnt >= ratio - W'(1)));
  assign tick_out = wrap;
  assign half_out = st_reg.half;

  always_comb begin
    st_next = st_reg;
    if (tick_in) begin
      if (wrap) begin
        st_next.cnt  = '0;
        st_next.half = ~st_reg.half;
      end else begin
        st_next.cnt = st_reg.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// *** verilog/sdc_top.sv ***
// The APB register port and the register offsets were chosen for this implementation.
`default_nettype none
module sdc_top
  import sdc_pkg::*;
#(
  parameter int M_WIDTH = sdc_pkg::M_W
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Configuration pins
  input  wire logic        par_load_n,
  input  wire logic [8:0]  m_in,
  input  wire logic [1:0]  n_in,
  input  wire logic        ser_clock,
  input  wire logic        ser_data,
  input  wire logic        ser_load,
  // Clock-domain stand-ins for the analog loop
  input  wire logic        phase_ref,
  input  wire logic        vco_tick,
  // Outputs
  output logic             synth_output,
  output logic             test_out,
  output logic [8:0]       m_active,
  output logic [1:0]       n_active,
  output logic [2:0]       t_active
);
  import sdc_pkg::*;

  function automatic logic [3:0] n_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    n_ratio = 4'h2;
      2'h1:    n_ratio = 4'h4;
      2'h2:    n_ratio = 4'h8;
      default: n_ratio = 4'h1;
    endcase
  endfunction

  function automatic logic pin_ok(input logic [2:0] s);
    pin_ok = (s[1] == s[2]);
  endfunction

  typedef struct packed {
    logic [2:0]       pl_s;
    logic [2:0]       sc_s;
    logic [2:0]       sd_s;
    logic [2:0]       sl_s;
    logic [2:0]       rf_s;
    logic             pl_q;
    logic             sc_q;
    logic             sl_q;
    logic             sc_prev;
    logic [SR_W-1:0]  shreg;
    logic [M_W-1:0]   m_lat;
    logic [N_W-1:0]   n_lat;
    logic [T_W-1:0]   t_lat;
    logic             ref_q;
    logic             quart;
    logic [1:0]       qcnt;
    logic             sw_mode;
    logic             sw_pl_n;
    logic             sw_sclk;
    logic             sw_sdat;
    logic             sw_sld;
    logic [31:0]      rdata;
  } sdc_st_t;

  sdc_st_t st_reg;
  sdc_st_t st_next;

  logic pl_n;
  logic sclk;
  logic sdat;
  logic sld;
  logic sc_rise;
  logic loop_tick;
  logic out_tick;
  logic m_tick;
  logic m_half;
  logic n_half;
  logic [3:0] nr;
  logic apb_acc;
  logic addr_ok;

  // Software can drive par_load_n and the three serial pins itself for board bring-up; m_in and n_in always come from the pins
  assign pl_n = st_reg.sw_mode ? st_reg.sw_pl_n : st_reg.pl_q;
  assign sclk = st_reg.sw_mode ? st_reg.sw_sclk : st_reg.sc_q;
  assign sdat = st_reg.sw_mode ? st_reg.sw_sdat : st_reg.sd_s[2];
  assign sld  = st_reg.sw_mode ? st_reg.sw_sld  : st_reg.sl_q;

  assign sc_rise = sclk && !st_reg.sc_prev;

  // bypass feeds dividers from serial clock
  assign loop_tick = (st_reg.t_lat == T_BYPASS) ? sc_rise : vco_tick;
  assign nr        = n_ratio(st_reg.n_lat);

  // output tracks loop_tick (vco, or serial clock in bypass) over N; loop over M
  sdc_divider #(.W(4)) u_ndiv (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .tick_in  (loop_tick),
    .ratio    (nr),
    .tick_out (out_tick),
    .half_out (n_half)
  );

  sdc_divider #(.W(M_W)) u_mdiv (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .tick_in  (loop_tick),
    .ratio    (st_reg.m_lat),
    .tick_out (m_tick),
    .half_out (m_half)
  );

  assign apb_acc = psel && penable;
  assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_PAR) || (paddr == REG_SHIFT)
                   || (paddr == REG_CFG) || (paddr == REG_STAT);

  always_comb begin
    st_next = st_reg;
    st_next.pl_s = {st_reg.pl_s[1:0], par_load_n};
    st_next.sc_s = {st_reg.sc_s[1:0], ser_clock};
    st_next.sd_s = {st_reg.sd_s[1:0], ser_data};
    st_next.sl_s = {st_reg.sl_s[1:0], ser_load};
    st_next.rf_s = {st_reg.rf_s[1:0], phase_ref};
    if (pin_ok(st_reg.pl_s)) st_next.pl_q = st_reg.pl_s[2];
    if (pin_ok(st_reg.sl_s)) st_next.sl_q = st_reg.sl_s[2];
    if (pin_ok(st_reg.rf_s)) st_next.ref_q = st_reg.rf_s[2];
    if (pin_ok(st_reg.sc_s)) st_next.sc_q = st_reg.sc_s[2];
    // Previous effective level kept out of the synchronizer chain
    st_next.sc_prev = sclk;
    // shift MSB-first stream; T ends on top
    if (sc_rise) begin
      st_next.shreg = {st_reg.shreg[SR_W-2:0], sdat};
    end
    if (!pl_n) begin
      // transparent, last value held at rise
      st_next.m_lat = m_in;
      st_next.n_lat = n_in;
      st_next.t_lat = T_RST;
    end else if (sld) begin
      st_next.t_lat = st_reg.shreg[SR_W-1 -: T_W];
      st_next.n_lat = st_reg.shreg[M_W +: N_W];
      st_next.m_lat = st_reg.shreg[M_W-1:0];
    end
    if (out_tick) begin
      st_next.qcnt = st_reg.qcnt + 2'h1;
      if (st_reg.qcnt == 2'h3) st_next.quart = ~st_reg.quart;
    end
    st_next.rdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL:  st_next.rdata = {27'h0, st_reg.sw_sld, st_reg.sw_sdat, st_reg.sw_sclk,
                                     st_reg.sw_pl_n, st_reg.sw_mode};
        REG_PAR:   st_next.rdata = {21'h0, n_in, m_in};
        REG_SHIFT: st_next.rdata = {18'h0, st_reg.shreg};
        REG_CFG:   st_next.rdata = {18'h0, st_reg.t_lat, st_reg.n_lat, st_reg.m_lat};
        REG_STAT:  st_next.rdata = {27'h0, test_out, synth_output, pl_n,
                                     (st_reg.m_lat >= 9'(M_MIN)) && (9'(st_reg.m_lat) <= 9'(M_MAX)),
                                     st_reg.t_lat == T_BYPASS};
        default:   st_next.rdata = 32'h0;
      endcase
    end else if (apb_acc) begin
      st_next.rdata = st_reg.rdata;
    end
    if (apb_acc && pwrite && paddr == REG_CTRL) begin
      st_next.sw_mode = pwdata[0];
      st_next.sw_pl_n = pwdata[1];
      st_next.sw_sclk = pwdata[2];
      st_next.sw_sdat = pwdata[3];
      st_next.sw_sld  = pwdata[4];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg         <= '0;
      st_reg.pl_s    <= 3'h7;
      st_reg.pl_q    <= 1'b1;
      st_reg.sw_pl_n <= 1'b1;
      st_reg.m_lat   <= M_RST;
      st_reg.n_lat   <= N_RST;
      st_reg.t_lat   <= T_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = apb_acc && !addr_ok;
  assign prdata  = st_reg.rdata;

  // N divider drives output in all modes
  assign synth_output = n_half;
  assign m_active     = st_reg.m_lat;
  assign n_active     = st_reg.n_lat;
  assign t_active     = st_reg.t_lat;

  always_comb begin
    case (st_reg.t_lat)
      T_SHIFT:  test_out = st_reg.shreg[SR_W-1];
      T_HIGH:   test_out = 1'b1;
      T_REF:    test_out = st_reg.ref_q;
      T_MHALF:  test_out = m_half;
      T_SYNTH:  test_out = n_half;
      T_LOW:    test_out = 1'b0;
      T_BYPASS: test_out = m_half;
      default:  test_out = st_reg.quart;
    endcase
  end

  // Assertions
  property p_force_t;
    @(posedge sys_clk) disable iff (rst) !pl_n |=> (t_active == T_RST);
  endproperty
  a_force_t: assert property (p_force_t) else $error("test select not forced");

  property p_par_cap;
    @(posedge sys_clk) disable iff (rst) !pl_n |=> (m_active == $past(m_in)) && (n_active == $past(n_in));
  endproperty
  a_par_cap: assert property (p_par_cap) else $error("parallel capture wrong");

  property p_hold;
    @(posedge sys_clk) disable iff (rst) (pl_n && !sld) |=> $stable(m_active) && $stable(t_active);
  endproperty
  a_hold: assert property (p_hold) else $error("dividers changed without load");

  property p_ser_lat;
    @(posedge sys_clk) disable iff (rst) (pl_n && sld) |=> (m_active == $past(st_reg.shreg[M_W-1:0]));
  endproperty
  a_ser_lat: assert property (p_ser_lat) else $error("serial latch wrong");

  property p_ser_t;
    @(posedge sys_clk) disable iff (rst) (pl_n && sld) |=> (t_active == $past(st_reg.shreg[SR_W-1 -: T_W]));
  endproperty
  a_ser_t: assert property (p_ser_t) else $error("serial test select wrong");

  property p_t_src;
    @(posedge sys_clk) disable iff (rst) !sld |=> $stable(t_active) || (t_active == T_RST);
  endproperty
  a_t_src: assert property (p_t_src) else $error("test select changed off the serial latch");

  property p_shift;
    @(posedge sys_clk) disable iff (rst) sc_rise |=> (st_reg.shreg[0] == $past(sdat));
  endproperty
  a_shift: assert property (p_shift) else $error("shift bit wrong");

  property p_hi;
    @(posedge sys_clk) disable iff (rst) (t_active == T_HIGH) |-> test_out;
  endproperty
  a_hi: assert property (p_hi) else $error("test high wrong");

  property p_t2;
    @(posedge sys_clk) disable iff (rst) !pl_n |=> (test_out == st_reg.shreg[SR_W-1]);
  endproperty
  a_t2: assert property (p_t2) else $error("shift out wrong");

  property p_ratio1;
    @(posedge sys_clk) disable iff (rst) (n_active == 2'h3) && loop_tick |-> out_tick;
  endproperty
  a_ratio1: assert property (p_ratio1) else $error("divide by one wrong");

  // Bypass at divide by one: every serial clock rise toggles the output
  sequence s_byp_rise;
    (t_active == T_BYPASS) && (n_active == 2'h3) && sc_rise;
  endsequence
  property p_byp;
    @(posedge sys_clk) disable iff (rst) s_byp_rise |=> (synth_output != $past(synth_output));
  endproperty
  a_byp: assert property (p_byp) else $error("bypass clock lost");
endmodule
`default_nettype wire

// *** sim/sdc_ctl_model.sv ***
`default_nettype none
// Board controller on the configuration pins
module sdc_ctl_model (
  // Clock
  input  wire logic  sys_clk,
  // Pins
  output logic       par_load_n,
  output logic [8:0] m_in,
  output logic [1:0] n_in,
  output logic       ser_clock,
  output logic       ser_data,
  output logic       ser_load
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels follow the pin pulls
  initial begin
    par_load_n = 1'h1;
    m_in = 9'h1ff;
    n_in = 2'h3;
    {ser_clock, ser_data, ser_load} = 3'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic par_open(input logic [8:0] m, input logic [1:0] n);
    par_load_n <= 1'h0;
    m_in <= m;
    n_in <= n;
    hold(6);
  endtask
  task automatic par_close();
    par_load_n <= 1'h1;
    hold(6);
    m_in <= 9'h1ff;
    n_in <= 2'h3;
  endtask
  // msb first, data steady around the rise
  task automatic shift(input logic [13:0] w);
    for (int i = 13; i >= 0; i--) begin
      ser_data <= w[i];
      hold(4);
      ser_clock <= 1'h1;
      hold(4);
      ser_clock <= 1'h0;
    end
    ser_data <= 1'h0;
    hold(4);
  endtask
  // pulse only after the full word
  task automatic latch();
    ser_load <= 1'h1;
    hold(6);
    ser_load <= 1'h0;
    hold(6);
  endtask
  // One serial clock period, used as the bypass test clock
  task automatic pulse();
    ser_clock <= 1'h1;
    hold(6);
    ser_clock <= 1'h0;
    hold(6);
  endtask
endmodule
`default_nettype wire

// *** sim/test_synth_divider_config.sv ***
`default_nettype none
module test_synth_divider_config import sdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic phase_ref = 1'h0, vco_tick = 1'h0, synth_output, test_out, pready, pslverr, er;
  logic par_load_n, ser_clock, ser_data, ser_load;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [8:0] m_in, m_active;
  logic [1:0] n_in, n_active;
  logic [2:0] t_active;
  int n_fail = 0, tests_run = 0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    vco_tick <= ~vco_tick;
  end
  // Reference pin moves slowly enough to pass the input filter
  always begin
    repeat (8) @(posedge sys_clk);
    phase_ref <= ~phase_ref;
  end
  sdc_top u_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .par_load_n, .m_in, .n_in, .ser_clock, .ser_data, .ser_load, .phase_ref, .vco_tick, .synth_output,
    .test_out, .m_active, .n_active, .t_active);
  sdc_ctl_model u_ctl (.sys_clk, .par_load_n, .m_in, .n_in, .ser_clock, .ser_data, .ser_load);
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Sampled mid-cycle so registered outputs have settled
  task automatic cfg(input logic [2:0] t, input logic [1:0] n, input logic [8:0] m);
    @(negedge sys_clk);
    chk("cfg", {18'h0, t, n, m}, {18'h0, t_active, n_active, m_active});
    @(posedge sys_clk);
  endtask
  task automatic pin(input logic e);
    @(negedge sys_clk);
    chk("test_out", {31'h0, e}, {31'h0, test_out});
    @(posedge sys_clk);
  endtask
  // Answer and read data are taken at the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, wd);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    for (int k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pready === 1'h1) begin
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Idle edge so a following call never drives psel twice in one step
        @(posedge sys_clk);
        return;
      end
    end
    n_fail++;
    wrap_up();
  endtask
  task automatic load(input logic [13:0] w);
    u_ctl.shift(w);
    u_ctl.latch();
  endtask
  // Level changes of both clock outputs over n cycles, after settling
  task automatic count(input int n, output int cs, output int ct);
    logic ps;
    logic pt;
    cs = 0;
    ct = 0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    ps = synth_output;
    pt = test_out;
    repeat (n) begin
      @(negedge sys_clk);
      if (synth_output !== ps) cs++;
      if (test_out !== pt) ct++;
      ps = synth_output;
      pt = test_out;
    end
    @(posedge sys_clk);
  endtask
  task automatic t_reset();
    cfg(T_RST, N_RST, M_RST);
    pin(1'h0);
  endtask
  task automatic t_par();
    u_ctl.par_open(9'h0c8, 2'h0);
    cfg(T_RST, 2'h0, 9'h0c8);
    u_ctl.par_open(9'h106, 2'h1);
    cfg(T_RST, 2'h1, 9'h106);
    apb(1'h0, REG_PAR, 32'h0);
    chk("par", {21'h0, 2'h1, 9'h106}, rd);
    u_ctl.par_close();
    cfg(T_RST, 2'h1, 9'h106);
  endtask
  task automatic t_ser();
    u_ctl.shift({T_LOW, 2'h2, 9'h12c});
    cfg(T_RST, 2'h1, 9'h106);
    apb(1'h0, REG_SHIFT, 32'h0);
    chk("shift", {18'h0, T_LOW, 2'h2, 9'h12c}, rd);
    u_ctl.latch();
    cfg(T_LOW, 2'h2, 9'h12c);
    pin(1'h0);
    load({T_HIGH, 2'h3, 9'h190});
    cfg(T_HIGH, 2'h3, 9'h190);
    pin(1'h1);
    apb(1'h0, REG_STAT, 32'h0);
    chk("stat", 32'h2, rd & 32'h3);
  endtask
  task automatic t_force();
    u_ctl.par_open(9'h0c8, 2'h2);
    cfg(T_RST, 2'h2, 9'h0c8);
    u_ctl.par_close();
    cfg(T_RST, 2'h2, 9'h0c8);
    pin(1'h0);
  endtask
  // Vco stand-in ticks every second cycle
  task automatic t_modes();
    int cs;
    int ct;
    load({T_QUART, 2'h3, 9'h0c8});
    count(64, cs, ct);
    chk("synth_div1", 32'h20, cs);
    chk("test_quarter", cs, 4 * ct);
    load({T_SYNTH, 2'h0, 9'h0c8});
    count(64, cs, ct);
    chk("synth_div2", 32'h10, cs);
    chk("test_synth", cs, ct);
  endtask
  task automatic t_ref();
    logic p;
    load({T_REF, 2'h3, 9'h0c8});
    p = phase_ref;
    for (int k = 0; k < 20 && phase_ref === p; k++) @(posedge sys_clk);
    repeat (5) @(posedge sys_clk);
    pin(phase_ref);
  endtask
  task automatic t_bypass();
    logic b;
    load({T_BYPASS, 2'h3, 9'h0c8});
    cfg(T_BYPASS, 2'h3, 9'h0c8);
    apb(1'h0, REG_STAT, 32'h0);
    chk("stat", 32'h3, rd & 32'h3);
    b = synth_output;
    u_ctl.pulse();
    chk("bypass_out", {31'h0, ~b}, {31'h0, synth_output});
    u_ctl.pulse();
    chk("bypass_out", {31'h0, b}, {31'h0, synth_output});
  endtask
  task automatic t_bus();
    apb(1'h0, 32'h0000_0020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    chk("unmapped", 32'h0, rd);
    apb(1'h1, REG_CTRL, 32'h2);
    apb(1'h0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h2, rd);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    t_reset();
    t_par();
    t_ser();
    t_force();
    t_modes();
    t_ref();
    t_bypass();
    t_bus();
    wrap_up();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
